// File: dpp_pkg.sv
// dpp_pkg: constants shared by the directional power protection element
// assumes a 100 MHz system clock and a 32-bit avalon-mm register port
package dpp_pkg;
   // register word indices (byte address = index * 4)
   localparam logic [3:0] DPP_REG_CTRL    = 4'h0;
   localparam logic [3:0] DPP_REG_ANGLE   = 4'h1;
   localparam logic [3:0] DPP_REG_POWER   = 4'h2;
   localparam logic [3:0] DPP_REG_DELAY   = 4'h3;
   localparam logic [3:0] DPP_REG_STATUS  = 4'h4;
   localparam logic [3:0] DPP_REG_IRQ     = 4'h5;
   localparam logic [3:0] DPP_REG_MASK    = 4'h6;
   localparam logic [3:0] DPP_REG_PQ      = 4'h7;
   // ctrl field positions
   localparam int DPP_CTRL_OPER  = 0;
   localparam int DPP_CTRL_SONLY = 1;
   // irq bits: start on, start off, trip on, trip off
   localparam int DPP_EV_ST_ON  = 0;
   localparam int DPP_EV_ST_OFF = 1;
   localparam int DPP_EV_TR_ON  = 2;
   localparam int DPP_EV_TR_OFF = 3;
   localparam int DPP_NEV       = 4;
   // reset values and write limits
   localparam logic        DPP_OPER_RST  = 1'b0;
   localparam logic        DPP_SONLY_RST = 1'b0;
   localparam logic [8:0]  DPP_ANGLE_RST = 9'h000;
   localparam logic [10:0] DPP_POWER_RST = 11'h064;
   localparam logic [15:0] DPP_DELAY_RST = 16'h00c8;
   localparam logic [8:0]  DPP_ANGLE_MIN = 9'h14d;
   localparam logic [8:0]  DPP_ANGLE_MAX = 9'h0b4;
   localparam logic [10:0] DPP_POWER_MIN = 11'h00a;
   localparam logic [10:0] DPP_POWER_MAX = 11'h7d0;
   localparam logic [15:0] DPP_DELAY_MIN = 16'h00c8;
   localparam logic [15:0] DPP_DELAY_MAX = 16'hea60;
   // hysteresis in 0.1 % of full-scale power, the same units as the start power setting
   localparam logic [10:0] DPP_HYST      = 11'h005;
   // timing
   localparam int DPP_CLK_HZ    = 100_000_000;
   localparam int DPP_MS_CYCLES = DPP_CLK_HZ / 1000;
   localparam logic [16:0] DPP_MS_CNT = 17'(DPP_MS_CYCLES);
endpackage : dpp_pkg

// File: dpp_element.sv
// dpp_element: directional under/over-power element with definite-time trip
// assumes phasor rms inputs already synchronous to i_clk; avalon-mm slave
module dpp_element
   import dpp_pkg::*;
#(
   parameter bit OVER_POWER = 1'b0
)
(
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_reset,
   // phase quantities: signed rms real/imag, voltage and current per phase
   input  wire logic signed [15:0] i_u_re [3],
   input  wire logic signed [15:0] i_u_im [3],
   input  wire logic signed [15:0] i_i_re [3],
   input  wire logic signed [15:0] i_i_im [3],
   // blocking inputs
   input  wire logic               i_general_block_in,
   input  wire logic               i_supervision_block_in,
   // avalon-mm slave
   input  wire logic [5:0]         i_avs_address,
   input  wire logic               i_avs_read,
   input  wire logic               i_avs_write,
   input  wire logic [31:0]        i_avs_writedata,
   output logic [31:0]             o_avs_readdata,
   output logic                    o_avs_waitrequest,
   // protection outputs
   output logic                    o_general_start_out,
   output logic                    o_general_trip_out,
   output logic                    o_irq
);

   // settings and register bus state
   logic               oper_q;
   logic               sonly_q;
   logic signed [8:0]  angle_q;
   logic [10:0]        power_q;
   logic [15:0]        delay_q;
   logic [DPP_NEV-1:0] irq_q;
   logic [DPP_NEV-1:0] mask_q;
   logic               ack_q;
   logic [31:0]        rdata_q;
   logic [3:0]         widx;
   logic               wr_hit;
   logic               rd_hit;

   // power and decision pipeline
   logic signed [33:0] p_q;
   logic signed [33:0] q_q;
   logic signed [17:0] cos_q;
   logic signed [17:0] sin_q;
   logic signed [51:0] proj_q;
   logic signed [51:0] thr_q;
   logic               dir_q;
   logic               start_q;
   logic               trip_q;
   logic               start_d1_q;
   logic               trip_d1_q;
   logic [16:0]        ms_pre_q;
   logic [15:0]        ms_cnt_q;
   logic               inhibit;
   logic [10:0]        eff_power;
   logic [DPP_NEV-1:0] ev_set;

   // degrees (0..90) to sine in q1.16, linear-interpolated parabola
   function automatic logic signed [17:0] dpp_sin_q1(input logic [6:0] deg);
      logic [31:0] x;
      x = 32'(deg) * 32'd728;
      dpp_sin_q1 = 18'(x + ((x * (32'd65536 - x)) >> 18));
   endfunction : dpp_sin_q1

   function automatic logic signed [17:0] dpp_sin(input logic signed [9:0] a);
      logic signed [9:0] m;
      logic neg;
      m = a;
      neg = 1'b0;
      // cosine argument can reach 269 degrees for angles below -90
      if (m > 10'sd180)
         m = m - 10'sd360;
      if (m < 0)
      begin
         m = -m;
         neg = 1'b1;
      end
      if (m > 10'sd90)
         m = 10'sd180 - m;
      dpp_sin = neg ? -dpp_sin_q1(7'(m)) : dpp_sin_q1(7'(m));
   endfunction : dpp_sin

   // register bus: one-cycle acceptance, waitrequest high until ack
   assign widx              = i_avs_address[5:2];
   // writes commit at the edge where waitrequest is low
   assign wr_hit            = i_avs_write && ack_q;
   assign rd_hit            = i_avs_read && !ack_q;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
   assign o_avs_readdata    = rdata_q;

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         ack_q <= 1'b0;
      else
         ack_q <= (i_avs_read || i_avs_write) && !ack_q;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         oper_q  <= DPP_OPER_RST;
         sonly_q <= DPP_SONLY_RST;
         angle_q <= DPP_ANGLE_RST;
         power_q <= DPP_POWER_RST;
         delay_q <= DPP_DELAY_RST;
         mask_q  <= '0;
      end
      else if (wr_hit)
      begin
         case (widx)
            DPP_REG_CTRL:
            begin
               oper_q  <= i_avs_writedata[DPP_CTRL_OPER];
               sonly_q <= i_avs_writedata[DPP_CTRL_SONLY];
            end
            DPP_REG_ANGLE:
            begin
               // out-of-range angles are ignored
               if ($signed(i_avs_writedata[8:0]) >= $signed(DPP_ANGLE_MIN)
                   && $signed(i_avs_writedata[8:0]) <= $signed(DPP_ANGLE_MAX))
                  angle_q <= i_avs_writedata[8:0];
            end
            DPP_REG_POWER:
            begin
               if (i_avs_writedata[31:11] == '0 && i_avs_writedata[10:0] >= DPP_POWER_MIN
                   && i_avs_writedata[10:0] <= DPP_POWER_MAX)
                  power_q <= i_avs_writedata[10:0];
            end
            DPP_REG_DELAY:
            begin
               if (i_avs_writedata[31:16] == '0 && i_avs_writedata[15:0] >= DPP_DELAY_MIN
                   && i_avs_writedata[15:0] <= DPP_DELAY_MAX)
                  delay_q <= i_avs_writedata[15:0];
            end
            DPP_REG_MASK:
               mask_q <= i_avs_writedata[DPP_NEV-1:0];
            default:
               ;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         rdata_q <= '0;
      else if (rd_hit)
      begin
         case (widx)
            DPP_REG_CTRL:   rdata_q <= {30'h0, sonly_q, oper_q};
            DPP_REG_ANGLE:  rdata_q <= 32'(angle_q);
            DPP_REG_POWER:  rdata_q <= {21'h0, power_q};
            DPP_REG_DELAY:  rdata_q <= {16'h0, delay_q};
            DPP_REG_STATUS: rdata_q <= {29'h0, dir_q, trip_q, start_q};
            DPP_REG_IRQ:    rdata_q <= {28'h0, irq_q};
            DPP_REG_MASK:   rdata_q <= {28'h0, mask_q};
            DPP_REG_PQ:     rdata_q <= {p_q[33:18], q_q[33:18]};
            default:        rdata_q <= 32'h0;
         endcase
      end
   end

   // P = sum(Ur*Ir + Ui*Ii), Q = sum(Ui*Ir - Ur*Ii)
   always_ff @(posedge i_clk)
   begin
      logic signed [33:0] ps;
      logic signed [33:0] qs;
      ps = '0;
      qs = '0;
      for (int k = 0; k < 3; k++)
      begin
         ps = ps + 34'(i_u_re[k] * i_i_re[k]) + 34'(i_u_im[k] * i_i_im[k]);
         qs = qs + 34'(i_u_im[k] * i_i_re[k]) - 34'(i_u_re[k] * i_i_im[k]);
      end
      if (i_reset)
      begin
         p_q <= '0;
         q_q <= '0;
      end
      else
      begin
         p_q <= ps;
         q_q <= qs;
      end
   end

   // hysteresis moves the line away from the operate side once operated
   always_comb
   begin
      if (!start_q)
         eff_power = power_q;
      else if (OVER_POWER)
         eff_power = (power_q > DPP_HYST) ? power_q - DPP_HYST : 11'h0;
      else
         eff_power = power_q + DPP_HYST;
   end

   // projection of S on the set-point direction against set-point magnitude;
   // full scale of p_q (2^30) maps to 100.0 % = 1000 units
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cos_q  <= '0;
         sin_q  <= '0;
         proj_q <= '0;
         thr_q  <= '0;
      end
      else
      begin
         cos_q  <= dpp_sin(10'sd90 - 10'(angle_q));
         sin_q  <= dpp_sin(10'(angle_q));
         proj_q <= 52'(p_q * cos_q) + 52'(q_q * sin_q);
         thr_q  <= 52'((64'(eff_power) << 46) / 64'd1000);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         dir_q <= 1'b0;
      else if (OVER_POWER)
         dir_q <= proj_q > thr_q;
      else
         dir_q <= proj_q < thr_q;
   end

   assign inhibit = !oper_q || i_general_block_in || i_supervision_block_in;

   always_ff @(posedge i_clk)
   begin
      if (i_reset || inhibit)
         start_q <= 1'b0;
      else
         start_q <= dir_q;
   end

   // millisecond timer: prescaler plus ms count
   always_ff @(posedge i_clk)
   begin
      // dropping decision clears trip together with start
      if (i_reset || inhibit || !start_q || !dir_q || sonly_q)
      begin
         ms_pre_q <= '0;
         ms_cnt_q <= '0;
         trip_q   <= 1'b0;
      end
      else if (ms_cnt_q >= delay_q)
         trip_q <= 1'b1;
      else if (ms_pre_q == DPP_MS_CNT - 17'h1)
      begin
         ms_pre_q <= '0;
         ms_cnt_q <= ms_cnt_q + 16'h1;
      end
      else
         ms_pre_q <= ms_pre_q + 17'h1;
   end

   assign o_general_start_out = start_q;
   assign o_general_trip_out  = trip_q;

   // edge events, sticky, write-one-to-clear, set wins
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         start_d1_q <= 1'b0;
         trip_d1_q  <= 1'b0;
      end
      else
      begin
         start_d1_q <= start_q;
         trip_d1_q  <= trip_q;
      end
   end

   assign ev_set = {!trip_q && trip_d1_q, trip_q && !trip_d1_q,
                    !start_q && start_d1_q, start_q && !start_d1_q};

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         irq_q <= '0;
      else if (wr_hit && widx == DPP_REG_IRQ)
         irq_q <= (irq_q & ~i_avs_writedata[DPP_NEV-1:0]) | ev_set;
      else
         irq_q <= irq_q | ev_set;
   end

   assign o_irq = |(irq_q & mask_q);

   chk_block_clears_start: assert property (@(posedge i_clk) disable iff (i_reset)
      inhibit |=> !o_general_start_out && !o_general_trip_out)
      else $error("start or trip held while inhibited");

   chk_trip_needs_start: assert property (@(posedge i_clk) disable iff (i_reset)
      o_general_trip_out |-> o_general_start_out)
      else $error("trip without start");

   chk_start_only_trip: assert property (@(posedge i_clk) disable iff (i_reset)
      sonly_q |=> !o_general_trip_out)
      else $error("trip while start only");

   chk_start_follows_dir: assert property (@(posedge i_clk) disable iff (i_reset)
      dir_q && !inhibit |=> o_general_start_out)
      else $error("start missed decision");

   chk_start_on_event: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(start_q) |=> irq_q[DPP_EV_ST_ON])
      else $error("start on event lost");

   chk_trip_on_event: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(trip_q) |=> irq_q[DPP_EV_TR_ON])
      else $error("trip on event lost");

   chk_trip_delay_min: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(trip_q) |-> ms_cnt_q >= delay_q)
      else $error("trip before delay");

   chk_hyst_band: assert property (@(posedge i_clk) disable iff (i_reset)
      start_q && !OVER_POWER |-> eff_power == power_q + DPP_HYST)
      else $error("under-power hysteresis wrong");

endmodule : dpp_element

// File: dpp_front_end.sv
// dpp_front_end: behavioural measurement front end and block-signal source
// assumes the bench commands a current level; voltages fixed, in phase
module dpp_front_end
   import dpp_pkg::*;
(
   // clock
   input  wire logic               i_clk,
   // commands from bench
   input  wire logic signed [15:0] i_cur,
   input  wire logic               i_blk,
   input  wire logic               i_vts,
   // phasors
   output logic signed [15:0]      o_u_re [3],
   output logic signed [15:0]      o_u_im [3],
   output logic signed [15:0]      o_i_re [3],
   output logic signed [15:0]      o_i_im [3],
   // block lines
   output logic                    o_blk,
   output logic                    o_vts
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge i_clk)
   begin
      for (int k = 0; k < 3; k++)
      begin
         // current in phase with voltage, so power is purely active
         o_u_re[k] <= 16'sh4000;
         o_u_im[k] <= 16'sh0000;
         o_i_re[k] <= i_cur;
         o_i_im[k] <= 16'sh0000;
      end
   end

   always_ff @(posedge i_clk)
   begin
      o_blk <= i_blk;
      o_vts <= i_vts;
   end
endmodule : dpp_front_end

// File: directional_power_protection_tb.sv
// directional_power_protection_tb: register and start-path tests
// assumes dpp_front_end model; trip delay too long to reach in this run
module directional_power_protection_tb
   import dpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // about 4.6 %, 10.2 %, 9.8 % and 36.6 % of full-scale power
   localparam logic signed [15:0] LOW  = 16'sh03e8;
   localparam logic signed [15:0] MID  = 16'sh08b4;
   localparam logic signed [15:0] MID2 = 16'sh085d;
   localparam logic signed [15:0] HIGH = 16'sh1f40;

   logic                clk;
   logic                reset;
   logic signed [15:0]  u_re [3];
   logic signed [15:0]  u_im [3];
   logic signed [15:0]  i_re [3];
   logic signed [15:0]  i_im [3];
   logic signed [15:0]  cur;
   logic                blk_cmd;
   logic                vts_cmd;
   logic                blk;
   logic                voltage_transformer_supervision;
   logic [5:0]          addr;
   logic                rd;
   logic                wr;
   logic [31:0]         wdata;
   logic [31:0]         rdata;
   logic                wreq;
   logic                start;
   logic                trip;
   logic                irq;
   logic                start_op;
   int                  miscompares;
   int                  total_checks;

   dpp_front_end u_fe (.i_clk(clk), .i_cur(cur), .i_blk(blk_cmd), .i_vts(vts_cmd),
      .o_u_re(u_re), .o_u_im(u_im), .o_i_re(i_re), .o_i_im(i_im),
      .o_blk(blk), .o_vts(voltage_transformer_supervision));

   dpp_element #(.OVER_POWER(1'b0)) u_dut (.i_clk(clk), .i_reset(reset),
      .i_u_re(u_re), .i_u_im(u_im), .i_i_re(i_re), .i_i_im(i_im),
      .i_general_block_in(blk), .i_supervision_block_in(voltage_transformer_supervision),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .o_general_start_out(start), .o_general_trip_out(trip), .o_irq(irq));

   // over-power variant on the same bus and phasors; only its start is watched
   dpp_element #(.OVER_POWER(1'b1)) u_dut_op (.i_clk(clk), .i_reset(reset),
      .i_u_re(u_re), .i_u_im(u_im), .i_i_re(i_re), .i_i_im(i_im),
      .i_general_block_in(blk), .i_supervision_block_in(voltage_transformer_supervision),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .o_avs_readdata(), .o_avs_waitrequest(),
      .o_general_start_out(start_op), .o_general_trip_out(), .o_irq());

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   // one avalon transfer, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      addr  <= {idx, 2'b00};
      rd    <= ~w;
      wr    <= w;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 32'h0, q);
      check(q, exp);
   endtask : rd_chk

   task automatic wr_reg(input logic [3:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr_reg

   task automatic wr_rb(input logic [3:0] idx, input logic [31:0] d, input logic [31:0] exp);
      wr_reg(idx, d);
      rd_chk(idx, exp);
   endtask : wr_rb

   task automatic settle;
      repeat (20) @(negedge clk);
   endtask : settle

   task automatic apply(input logic signed [15:0] c, input logic b, input logic v);
      @(posedge clk);
      cur     <= c;
      blk_cmd <= b;
      vts_cmd <= v;
      settle();
   endtask : apply

   initial
   begin
      miscompares = 0;
      total_checks = 0;
      reset = 1'b1;
      cur = LOW;
      blk_cmd = 1'b0;
      vts_cmd = 1'b0;
      addr = 6'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd_chk(DPP_REG_CTRL, 32'h0);
      rd_chk(DPP_REG_ANGLE, 32'h0);
      rd_chk(DPP_REG_POWER, 32'h64);
      rd_chk(DPP_REG_DELAY, 32'hc8);
      rd_chk(DPP_REG_MASK, 32'h0);
      rd_chk(4'h8, 32'h0);
      wr_rb(DPP_REG_ANGLE, 32'h0b5, 32'h0);
      wr_rb(DPP_REG_ANGLE, 32'h14c, 32'h0);
      wr_rb(DPP_REG_POWER, 32'h009, 32'h64);
      wr_rb(DPP_REG_POWER, 32'h7d1, 32'h64);
      wr_rb(DPP_REG_POWER, 32'h7d0, 32'h7d0);
      wr_rb(DPP_REG_POWER, 32'h064, 32'h64);
      wr_rb(DPP_REG_DELAY, 32'h0c7, 32'hc8);
      wr_rb(DPP_REG_DELAY, 32'hea61, 32'hc8);
      wr_rb(DPP_REG_DELAY, 32'hea60, 32'hea60);
      apply(LOW, 1'b0, 1'b0);
      check(start, 1'b0);
      wr_reg(DPP_REG_CTRL, 32'h1);
      settle();
      check(start, 1'b1);
      check(start_op, 1'b0);
      rd_chk(DPP_REG_STATUS, 32'h5);
      // operated under-power holds below 10.5 %
      apply(MID, 1'b0, 1'b0);
      check(start, 1'b1);
      check(start_op, 1'b1);
      apply(HIGH, 1'b0, 1'b0);
      check(start, 1'b0);
      apply(MID, 1'b0, 1'b0);
      check(start, 1'b0);
      // operated over-power holds above 9.5 %
      apply(MID2, 1'b0, 1'b0);
      check(start, 1'b1);
      check(start_op, 1'b1);
      apply(HIGH, 1'b0, 1'b0);
      // set point on the negative active axis: large positive power operates
      wr_rb(DPP_REG_ANGLE, 32'h0b4, 32'h0b4);
      settle();
      check(start, 1'b1);
      check(start_op, 1'b0);
      wr_reg(DPP_REG_ANGLE, 32'h0);
      settle();
      check(start, 1'b0);
      rd_chk(DPP_REG_IRQ, 32'h3);
      check(irq, 1'b0);
      wr_reg(DPP_REG_MASK, 32'h1);
      settle();
      check(irq, 1'b1);
      wr_rb(DPP_REG_IRQ, 32'h1, 32'h2);
      check(irq, 1'b0);
      wr_rb(DPP_REG_IRQ, 32'h2, 32'h0);
      apply(LOW, 1'b1, 1'b0);
      check(start, 1'b0);
      rd_chk(DPP_REG_STATUS, 32'h4);
      apply(LOW, 1'b0, 1'b0);
      check(start, 1'b1);
      apply(LOW, 1'b0, 1'b1);
      check(start, 1'b0);
      apply(LOW, 1'b0, 1'b0);
      check(start, 1'b1);
      wr_reg(DPP_REG_CTRL, 32'h0);
      settle();
      check(start, 1'b0);
      check(trip, 1'b0);
      results();
   end

   initial
   begin
      #100_000;
      miscompares++;
      results();
   end
endmodule : directional_power_protection_tb
